/* core/fiow_pin_sync.sv */
/*
  Three-stage synchroniser for a bundle of slow pins with agreement filter.
  Assumes pins change slowly compared to the clock; the output only follows
  once the second and third stages agree.
*/
`timescale 1ns/1ps
module fiow_pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Pins and filtered copy
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] pin_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per bit, a change counts only when two settled stages agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pin_o[i] <= 1'b0;
      end else if (s2_q[i] == s3_q[i]) begin
        pin_o[i] <= s3_q[i];
      end
    end
  end

endmodule : fiow_pin_sync

/* core/fiow_pkg.sv */
/*
  Constants of the field I/O watchdog and fault supervisor: register offsets,
  field positions, reset values and timing counts.
  Assumes a 100 MHz core clock and an 8-bit code scanner with a 36.3 V full scale.
*/
package fiow_pkg;

  // Clock and link timing
  localparam int CLK_HZ          = 100_000_000;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int OPER_BAUD       = 2_500_000;
  localparam int SETUP_BAUD      = 115_200;
  localparam int OPER_BIT_CYC    = CLK_HZ / OPER_BAUD;
  localparam int SETUP_BIT_CYC   = CLK_HZ / SETUP_BAUD;
  localparam int MAX_UPDATE_HZ   = 10_000;
  localparam int MS_NS           = 1_000_000;
  localparam int MS_CYC          = MS_NS / CLK_PERIOD_NS;

  // Watchdog and activity lamp
  localparam logic [15:0] WDT_DEFAULT_MS = 16'h0032;
  localparam int ACT_UPDATE_HZ   = 1000;
  localparam int ACT_BLINK_HZ    = 1;
  localparam int ACT_TOGGLE      = ACT_UPDATE_HZ / (2 * ACT_BLINK_HZ);

  // Input classification
  localparam int PCT_FULL        = 100;
  localparam int HI_PCT          = 60;
  localparam int LO_PCT          = 40;
  localparam int FULL_SCALE_MV   = 36300;
  localparam int ENC_THR_MV      = 2500;
  localparam int ADC_MAX         = 255;
  localparam int ENC_THR_CODE    = (ENC_THR_MV * ADC_MAX + FULL_SCALE_MV / 2) / FULL_SCALE_MV;

  // Sizes
  localparam int N_IN            = 32;
  localparam int N_OUT           = 16;
  localparam int OUT_PER_CHIP    = 8;
  localparam int N_CHIP          = N_OUT / OUT_PER_CHIP;
  localparam int N_ANA           = 4;
  localparam int ENC_FIRST_IN    = 16;
  localparam int N_ENC           = 2;

  // Register offsets
  localparam logic [7:0] ADDR_OUTPUT = 8'h00;
  localparam logic [7:0] ADDR_INPUT  = 8'h04;
  localparam logic [7:0] ADDR_FAULT  = 8'h08;
  localparam logic [7:0] ADDR_WORK   = 8'h0c;
  localparam logic [7:0] ADDR_STORED = 8'h10;
  localparam logic [7:0] ADDR_MODE   = 8'h14;
  localparam logic [7:0] ADDR_ANALOG = 8'h18;
  localparam logic [7:0] ADDR_ENC    = 8'h1c;
  localparam logic [7:0] ADDR_OUTFLT = 8'h20;

  // Fault register bits
  localparam int FLT_WDOG        = 0;
  localparam int FLT_SHORT       = 1;
  localparam int FLT_OTEMP       = 2;
  localparam int FLT_LOWV        = 3;
  localparam int FLT_FLOSS       = 4;

  // Mode register fields
  localparam int MODE_PD_LSB     = 0;
  localparam int MODE_ENC_LSB    = 4;
  localparam logic [1:0] PD_IO_ONLY = 2'h0;
  localparam logic [1:0] PD_ENC     = 2'h2;
  localparam logic [1:0] PD_ENC_ALT = 2'h3;
  localparam logic [2:0] ENC_1X_FWD = 3'h0;
  localparam logic [2:0] ENC_1X_REV = 3'h1;
  localparam logic [2:0] ENC_2X_FWD = 3'h2;
  localparam logic [2:0] ENC_2X_REV = 3'h3;
  localparam logic [2:0] ENC_4X_FWD = 3'h4;
  localparam logic [2:0] ENC_4X_REV = 3'h5;

endpackage : fiow_pkg

/* core/fiow_supervisor.sv */
/*
  Field I/O supervisor: watchdog, fault flag, output gating, output faults,
  supply faults, input classification, analog readout, handwheel counters,
  lamps and link bit timing, all behind a classic Wishbone slave.
  Assumes a scanner on the same clock delivering 8-bit pin codes, and slow pins
  for supply status, driver flags and jumpers.
*/
`timescale 1ns/1ps
// Function
// RL1 - Thirty-two inputs and sixteen outputs exchanged with the host as process data.
// RL2 - Operate link runs at 2.5 Mbaud; updates up to 10 kHz.
// RL3 - Setup mode fixes the link at 115.2 kbaud.
// RL4 - Short circuit switches off that output and flags a fault.
// RL5 - Driver over-temperature disables its eight outputs and flags a fault.
// RL6 - Input high at 60 percent of supply, low at 40 percent.
// RL7 - Input voltages read as 8-bit codes, full scale 36.3 V.
// RL8 - Modes 1 and 2 also deliver analog codes of inputs 0 to 3.
// RL9 - Encoder mode uses inputs 16 to 19 with a 2.5 V threshold.
// RL10 - Counter mode 0..5: 1X, 2X, 4X forward and reverse; default 0.
// RL11 - No host access within the period sets fault, outputs off; default 50 ms.
// RL12 - Output updates ignored while fault is set; host clears it.
// RL13 - Fault flag is set coming out of power-up.
// RL14 - Period in milliseconds; zero disables the watchdog.
// RL15 - Stored and working watchdog periods are kept separately.
// RL16 - At power-up stored settings are copied into working ones.
// RL17 - A missing field supply blocks start and reports low voltage.
// RL18 - With separate logic supply, field voltage loss is reported.
// RL19 - Power-up: fault lamp on, activity lamp off; fault lamp off once running.
// RL20 - Activity lamp blinks about 1 Hz at 1 kHz update rate.
// RL21 - Setup mode lights both lamps continuously.
// RL22 - Each process data access restarts the watchdog from the working period.
module fiow_supervisor
  import fiow_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // Pins: jumpers, supplies, driver flags
  input  wire logic                 setup_mode_jumper,
  input  wire logic                 logic_supply_separate,
  input  wire logic                 field_supply_upper_bank_ok,
  input  wire logic                 field_supply_lower_bank_ok,
  input  wire logic [N_OUT-1:0]     out_short,
  input  wire logic [N_CHIP-1:0]    chip_overtemp,
  // Pin code scanner
  input  wire logic                 adc_valid,
  input  wire logic [4:0]           adc_chan,
  input  wire logic [7:0]           adc_code,
  input  wire logic [7:0]           field_supply_upper_bank_code,
  input  wire logic [7:0]           field_supply_lower_bank_code,
  // Field outputs, lamps, link timing
  output logic      [N_OUT-1:0]     field_out,
  output logic                      fault_lamp,
  output logic                      activity_lamp,
  output logic                      link_bit_tick
);

  localparam int SYNC_W = N_OUT + N_CHIP + 4;

  logic [1:0]           rst_sync_q;
  logic                 rst_n;
  logic [SYNC_W-1:0]    pins_s;
  logic [N_OUT-1:0]     short_s;
  logic [N_CHIP-1:0]    otemp_s;
  logic                 setup_s;
  logic                 sep_s;
  logic                 supplies_ok;
  logic [3:0]           settle_q;
  logic                 ack_q;
  logic [31:0]          rdata_q;
  logic                 wr;
  logic                 rd;
  logic                 pd_access;
  logic [N_OUT-1:0]     out_q;
  logic                 fault_q;
  logic                 fault_clr;
  logic                 started_q;
  logic                 lowv_q;
  logic                 floss_q;
  logic [N_OUT-1:0]     short_lat_q;
  logic [N_CHIP-1:0]    otemp_lat_q;
  logic [N_OUT-1:0]     chip_off;
  logic [15:0]          work_q;
  logic [15:0]          stored_q;
  logic                 load_pend_q;
  logic [31:0]          ms_cnt_q;
  logic [15:0]          wd_cnt_q;
  logic                 wd_expire;
  logic [1:0]           pd_mode_q;
  logic [2:0]           enc_mode_q;
  logic                 enc_active;
  logic [N_IN-1:0]      in_q;
  logic [15:0]          cls_lhs;
  logic [15:0]          cls_sup;
  logic [7:0]           ana_q [N_ANA];
  logic [15:0]          enc_q [N_ENC];
  logic [9:0]           act_cnt_q;
  logic                 act_q;
  logic [9:0]           bit_cnt_q;
  logic                 bit_tick_q;

  // Reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Synced pins read 0 for four edges; supplies look absent until then
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_q <= 4'h0;
    end else begin
      settle_q <= {settle_q[2:0], 1'b1};
    end
  end

  fiow_pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pin_i ({out_short, chip_overtemp, setup_mode_jumper, logic_supply_separate,
             field_supply_upper_bank_ok, field_supply_lower_bank_ok}),
    .pin_o (pins_s)
  );
  assign short_s     = pins_s[SYNC_W-1 -: N_OUT];
  assign otemp_s     = pins_s[N_CHIP+3 -: N_CHIP];
  assign setup_s     = pins_s[3];
  assign sep_s       = pins_s[2];
  assign supplies_ok = pins_s[1] & pins_s[0];

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // Bus slave: one wait state, ack lasts one cycle
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
  assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q;
  assign pd_access = (wr && wb_adr_i == ADDR_OUTPUT) || (rd && wb_adr_i == ADDR_INPUT);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0;
    end else if (rd) begin
      unique case (wb_adr_i)
        ADDR_OUTPUT: rdata_q <= {16'h0, out_q};
        ADDR_INPUT:  rdata_q <= in_q; // RL1
        ADDR_FAULT:  rdata_q <= {27'h0, floss_q, lowv_q, |otemp_lat_q, |short_lat_q, fault_q};
        ADDR_WORK:   rdata_q <= {16'h0, work_q};
        ADDR_STORED: rdata_q <= {16'h0, stored_q};
        ADDR_MODE:   rdata_q <= {25'h0, enc_mode_q, 2'h0, pd_mode_q};
        ADDR_ANALOG: rdata_q <= (pd_mode_q == PD_IO_ONLY) ? 32'h0 :
                                {ana_q[3], ana_q[2], ana_q[1], ana_q[0]}; // RL8
        ADDR_ENC:    rdata_q <= enc_active ? {enc_q[1], enc_q[0]} : 32'h0;
        ADDR_OUTFLT: rdata_q <= {14'h0, otemp_lat_q, short_lat_q};
        default:     rdata_q <= 32'h0;
      endcase
    end
  end

  // Output image; refused while faulted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 16'h0;
    end else if (wr && wb_adr_i == ADDR_OUTPUT && !fault_q) begin // RL12
      out_q <= 16'(merge({16'h0, out_q}, wb_dat_i, wb_sel_i));
    end
  end

  // Output faults latch until written one and gone; set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      short_lat_q <= 16'h0;
      otemp_lat_q <= 2'h0;
    end else begin
      short_lat_q <= short_s | (short_lat_q & ~((wr && wb_adr_i == ADDR_OUTFLT && wb_sel_i[0] && wb_sel_i[1])
                     ? wb_dat_i[15:0] : 16'h0)); // RL4
      otemp_lat_q <= otemp_s | (otemp_lat_q & ~((wr && wb_adr_i == ADDR_OUTFLT && wb_sel_i[2])
                     ? wb_dat_i[17:16] : 2'h0)); // RL5
    end
  end

  for (genvar c = 0; c < N_CHIP; c++) begin : g_chip
    assign chip_off[c*OUT_PER_CHIP +: OUT_PER_CHIP] = {OUT_PER_CHIP{otemp_lat_q[c]}}; // RL5
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      field_out <= 16'h0;
    end else begin
      field_out <= fault_q ? 16'h0 : (out_q & ~short_lat_q & ~chip_off); // RL4 RL11 RL12
    end
  end

  // Fault flag; clear refused until both field supplies are present
  assign fault_clr = wr && wb_adr_i == ADDR_FAULT && wb_sel_i[0] && wb_dat_i[FLT_WDOG] && supplies_ok; // RL17

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_q   <= 1'b1; // RL13
      started_q <= 1'b0;
    end else begin
      if (wd_expire) begin
        fault_q <= 1'b1; // RL11
      end else if (fault_clr) begin
        fault_q <= 1'b0; // RL12
      end
      if (fault_clr) begin
        started_q <= 1'b1;
      end
    end
  end

  // Supply faults, sticky, cleared by writing one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowv_q  <= 1'b0;
      floss_q <= 1'b0;
    end else begin
      if (settle_q[3] && !started_q && !supplies_ok) begin
        lowv_q <= 1'b1; // RL17
      end else if (wr && wb_adr_i == ADDR_FAULT && wb_sel_i[0] && wb_dat_i[FLT_LOWV]) begin
        lowv_q <= 1'b0;
      end
      if (started_q && sep_s && !supplies_ok) begin
        floss_q <= 1'b1; // RL18
      end else if (wr && wb_adr_i == ADDR_FAULT && wb_sel_i[0] && wb_dat_i[FLT_FLOSS]) begin
        floss_q <= 1'b0;
      end
    end
  end

  // Watchdog settings; working copy loaded from stored once after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stored_q    <= WDT_DEFAULT_MS;
      work_q      <= WDT_DEFAULT_MS;
      load_pend_q <= 1'b1;
    end else begin
      load_pend_q <= 1'b0;
      if (wr && wb_adr_i == ADDR_STORED) begin
        stored_q <= 16'(merge({16'h0, stored_q}, wb_dat_i, wb_sel_i)); // RL15
      end
      if (load_pend_q) begin
        work_q <= stored_q; // RL16
      end else if (wr && wb_adr_i == ADDR_WORK) begin
        work_q <= 16'(merge({16'h0, work_q}, wb_dat_i, wb_sel_i)); // RL15
      end
    end
  end

  // Millisecond countdown; zero period never bites
  assign wd_expire = (work_q != 16'h0) && (wd_cnt_q == 16'h1) && (ms_cnt_q == 32'(MS_CYCLES - 1)); // RL14

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_q <= 32'h0;
      wd_cnt_q <= WDT_DEFAULT_MS;
    end else if (pd_access || load_pend_q) begin
      ms_cnt_q <= 32'h0;
      wd_cnt_q <= load_pend_q ? stored_q : work_q; // RL22
    end else if (ms_cnt_q == 32'(MS_CYCLES - 1)) begin
      ms_cnt_q <= 32'h0;
      if (wd_cnt_q != 16'h0) begin
        wd_cnt_q <= wd_cnt_q - 16'h1; // RL11 RL14
      end
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'h1;
    end
  end

  // Mode register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_mode_q  <= PD_IO_ONLY;
      enc_mode_q <= ENC_1X_FWD; // RL10
    end else if (wr && wb_adr_i == ADDR_MODE && wb_sel_i[0]) begin
      pd_mode_q  <= wb_dat_i[MODE_PD_LSB +: 2];
      enc_mode_q <= wb_dat_i[MODE_ENC_LSB +: 3];
    end
  end
  // Both codes accepted since the mode number is given two ways
  assign enc_active = (pd_mode_q == PD_ENC) || (pd_mode_q == PD_ENC_ALT); // RL9

  // Input classification from scanned codes, hysteresis holds the middle band
  assign cls_lhs = 16'(adc_code) * 16'(PCT_FULL);
  assign cls_sup = (adc_chan < 5'(ENC_FIRST_IN)) ? 16'(field_supply_upper_bank_code)
                                                 : 16'(field_supply_lower_bank_code);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_q <= 32'h0;
      for (int a = 0; a < N_ANA; a++) begin
        ana_q[a] <= 8'h0;
      end
    end else if (adc_valid) begin
      if (enc_active && adc_chan >= 5'(ENC_FIRST_IN) && adc_chan < 5'(ENC_FIRST_IN + 2 * N_ENC)) begin
        in_q[adc_chan] <= (adc_code >= 8'(ENC_THR_CODE)); // RL9
      end else if (cls_lhs >= cls_sup * 16'(HI_PCT)) begin
        in_q[adc_chan] <= 1'b1; // RL6
      end else if (cls_lhs <= cls_sup * 16'(LO_PCT)) begin
        in_q[adc_chan] <= 1'b0; // RL6
      end
      if (adc_chan < 5'(N_ANA)) begin
        ana_q[adc_chan[1:0]] <= adc_code; // RL7 RL8
      end
    end
  end

  // Handwheel quadrature counters
  for (genvar e = 0; e < N_ENC; e++) begin : g_enc
    logic [1:0] ab_prev_q;
    logic       a;
    logic       b;
    logic       step;
    logic       up;
    logic       cnt_en;
    assign a    = in_q[ENC_FIRST_IN + 2*e];
    assign b    = in_q[ENC_FIRST_IN + 2*e + 1];
    assign step = (a ^ ab_prev_q[1]) ^ (b ^ ab_prev_q[0]);
    assign up   = (ab_prev_q[1] ^ b) ^ enc_mode_q[0];
    always_comb begin
      unique case (enc_mode_q)
        ENC_1X_FWD, ENC_1X_REV: cnt_en = step && (a ^ ab_prev_q[1]) && a; // RL10
        ENC_2X_FWD, ENC_2X_REV: cnt_en = step && (a ^ ab_prev_q[1]);
        ENC_4X_FWD, ENC_4X_REV: cnt_en = step;
        default:                cnt_en = 1'b0;
      endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ab_prev_q <= 2'h0;
        enc_q[e]  <= 16'h0;
      end else begin
        ab_prev_q <= {a, b};
        if (enc_active && cnt_en) begin
          enc_q[e] <= up ? enc_q[e] + 16'h1 : enc_q[e] - 16'h1; // RL9
        end
      end
    end
  end

  // Activity lamp toggles every half blink period of exchanges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_cnt_q <= 10'h0;
      act_q     <= 1'b0; // RL19
    end else if (fault_q) begin
      act_cnt_q <= 10'h0;
      act_q     <= 1'b0;
    end else if (pd_access) begin
      if (act_cnt_q == 10'(ACT_TOGGLE - 1)) begin
        act_cnt_q <= 10'h0;
        act_q     <= ~act_q; // RL20
      end else begin
        act_cnt_q <= act_cnt_q + 10'h1;
      end
    end
  end
  assign fault_lamp    = setup_s | fault_q; // RL19 RL21
  assign activity_lamp = setup_s | act_q; // RL21

  // Bit timing for the serial engine; rate follows the jumper
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q  <= 10'h0;
      bit_tick_q <= 1'b0;
    end else if (bit_cnt_q >= (setup_s ? 10'(SETUP_BIT_CYC - 1) : 10'(OPER_BIT_CYC - 1))) begin
      bit_cnt_q  <= 10'h0; // RL2 RL3
      bit_tick_q <= 1'b1;
    end else begin
      bit_cnt_q  <= bit_cnt_q + 10'h1;
      bit_tick_q <= 1'b0;
    end
  end
  assign link_bit_tick = bit_tick_q;

  sequence wb_req_s;
    wb_cyc_i && wb_stb_i && !ack_q;
  endsequence
  sequence ack_pulse_s;
    ack_q ##1 !ack_q;
  endsequence

  bus_ack_a: assert property (@(posedge clk) disable iff (!rst_n) wb_req_s |=> ack_pulse_s)
    else $error("ack not a single pulse after request");
  fault_reset_a: assert property (@(posedge clk) $rose(rst_n) |-> fault_q) // RL13
    else $error("fault flag not set after reset");
  out_block_a: assert property (@(posedge clk) disable iff (!rst_n) fault_q |=> field_out == 16'h0) // RL12
    else $error("outputs driven while faulted");
  out_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fault_q && wr && wb_adr_i == ADDR_OUTPUT) |=> out_q == $past(out_q)) // RL12
    else $error("output image changed while faulted");
  short_off_a: assert property (@(posedge clk) disable iff (!rst_n) (short_lat_q != 16'h0) |=> (field_out & $past(short_lat_q)) == 16'h0) // RL4
    else $error("shorted output still driven");
  chip_off_a: assert property (@(posedge clk) disable iff (!rst_n) // RL5
    (otemp_lat_q != 2'h0) |=> (field_out & $past(chip_off)) == 16'h0)
    else $error("hot driver chip still driven");
  wd_bite_a: assert property (@(posedge clk) disable iff (!rst_n) wd_expire |=> fault_q ##1 field_out == 16'h0) // RL11
    else $error("watchdog expiry did not fault");
  wd_zero_a: assert property (@(posedge clk) disable iff (!rst_n) (work_q == 16'h0 && !fault_q) |=> !fault_q) // RL14
    else $error("disabled watchdog expired");
  wd_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pd_access && !load_pend_q) |=> wd_cnt_q == $past(work_q) && ms_cnt_q == 32'h0) // RL22
    else $error("access did not restart watchdog");
  lv_start_a: assert property (@(posedge clk) disable iff (!rst_n) // RL17
    (settle_q[3] && !started_q && !supplies_ok) |=> lowv_q && fault_q)
    else $error("missing supply did not block start");
  setup_lamp_a: assert property (@(posedge clk) disable iff (!rst_n) setup_s |-> fault_lamp && activity_lamp) // RL21
    else $error("setup lamps not both lit");
  bit_gap_a: assert property (@(posedge clk) disable iff (!rst_n) bit_tick_q |=> !bit_tick_q [*8]) // RL2
    else $error("bit ticks too close");

endmodule : fiow_supervisor

/* verification/fiow_host_model.sv */
/*
  Host model: classic Wishbone master standing in for the serial host.
  Assumes the slave acks every request; the bench timeout cuts any hang.
*/
`timescale 1ns/1ps
module fiow_host_model
  import fiow_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Wishbone master side
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat,
  input  wire logic        ack,
  input  wire logic [31:0] rdat
);
  initial begin
    {cyc, stb, we, adr, sel, dat} = '0;
  end

  // Request held until ack is sampled, then released for a cycle
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask : acc

  // Clearing is the host's duty before outputs work
  task clear_fault(output logic [31:0] q);
    acc(1'b1, ADDR_FAULT, 32'h1, q);
  endtask : clear_fault
endmodule : fiow_host_model

/* verification/fiow_supervisor_tb.sv */
/*
  Self-checking bench of the supervisor through its Wishbone port and pins.
  Assumes MS_CYCLES of 10, so one ms is ten clocks.
*/
`timescale 1ns/1ps
module fiow_supervisor_tb;
  import fiow_pkg::*;
  logic        clk, arst_n, cyc, stb, we, ack, jmp, ok_up, ok_lo, sep, av, tick, flamp, alamp;
  logic [7:0]  adr, acode;
  logic [3:0]  sel;
  logic [31:0] wd, rdat, q;
  logic [15:0] shrt, fout;
  logic [1:0]  otmp;
  logic [4:0]  ach;
  int          fail_count, checks, cyc_n, n;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  fiow_host_model host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat(wd), .ack(ack), .rdat(rdat));

  fiow_supervisor #(.MS_CYCLES(10)) DUT (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rdat), .wb_ack_o(ack), .setup_mode_jumper(jmp), .logic_supply_separate(sep),
    .field_supply_upper_bank_ok(ok_up), .field_supply_lower_bank_ok(ok_lo), .out_short(shrt),
    .chip_overtemp(otmp), .adc_valid(av), .adc_chan(ach), .adc_code(acode),
    .field_supply_upper_bank_code(8'hc8), .field_supply_lower_bank_code(8'hc8),
    .field_out(fout), .fault_lamp(flamp), .activity_lamp(alamp), .link_bit_tick(tick));

  task print_verdict;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // Whole run is a few thousand clocks
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fail_count++;
      print_verdict;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wt(input int c);
    repeat (c) @(posedge clk);
  endtask : wt

  task wr(input logic [7:0] a, input logic [31:0] d);
    host.acc(1'b1, a, d, q);
  endtask : wr

  task rd(input logic [7:0] a);
    host.acc(1'b0, a, 32'h0, q);
  endtask : rd

  task adc(input logic [4:0] c, input logic [7:0] v);
    av <= 1'b1;
    ach <= c;
    acode <= v;
    @(posedge clk);
    av <= 1'b0;
    @(posedge clk);
  endtask : adc

  // Edges between two ticks; run twice so a partial period is skipped
  task period;
    repeat (2) begin
      while (tick !== 1'b1) @(posedge clk);
      @(posedge clk);
      n = 1;
      while (tick !== 1'b1) begin
        @(posedge clk);
        n++;
      end
    end
  endtask : period

  task t_reset;
    chk(32'(flamp), 32'h1);
    chk(32'(alamp), 32'h0);
    rd(ADDR_FAULT);
    chk(32'(q[4:0]), 32'h1);
    rd(ADDR_WORK);
    chk(q, 32'h32);
    rd(ADDR_STORED);
    chk(q, 32'h32);
  endtask : t_reset

  task t_gate;
    wr(ADDR_WORK, 32'h0);
    wr(ADDR_OUTPUT, 32'h1234);
    wt(3);
    chk(32'(fout), 32'h0);
    host.clear_fault(q);
    wr(ADDR_OUTPUT, 32'h1234);
    wt(2);
    chk(32'(flamp), 32'h0);
    chk(32'(fout), 32'h1234);
  endtask : t_gate

  task t_short;
    shrt <= 16'h0004;
    wt(10);
    chk(32'(fout), 32'h1230);
    rd(ADDR_FAULT);
    chk(32'(q[1]), 32'h1);
    otmp <= 2'h2;
    wt(10);
    chk(32'(fout), 32'h0030);
    shrt <= 16'h0;
    otmp <= 2'h0;
    wt(8);
    wr(ADDR_OUTFLT, 32'h3ffff);
    wt(2);
    chk(32'(fout), 32'h1234);
  endtask : t_short

  task t_wdog;
    wr(ADDR_WORK, 32'h2);
    repeat (4) begin
      wt(12);
      wr(ADDR_OUTPUT, 32'h1234);
    end
    rd(ADDR_FAULT);
    chk(32'(q[0]), 32'h0);
    wt(40);
    rd(ADDR_FAULT);
    chk(32'(q[0]), 32'h1);
    chk(32'(fout), 32'h0);
    ok_lo <= 1'b0;
    wt(8);
    host.clear_fault(q);
    rd(ADDR_FAULT);
    chk(32'(q[0]), 32'h1);
    chk(32'(q[4]), 32'h1);
    ok_lo <= 1'b1;
    wt(8);
    host.clear_fault(q);
    wr(ADDR_OUTPUT, 32'h1234);
    wr(ADDR_WORK, 32'h0);
    wt(60);
    rd(ADDR_FAULT);
    chk(32'(q[0]), 32'h0);
  endtask : t_wdog

  task t_setup;
    jmp <= 1'b1;
    wt(8);
    chk(32'({flamp, alamp}), 32'h3);
    period;
    chk(32'(n), 32'd868);
    jmp <= 1'b0;
    wt(8);
    period;
    chk(32'(n), 32'd40);
  endtask : t_setup

  // Supply code 200: high at 120, low at 80, hold between
  task t_inputs;
    adc(5'd0, 8'd120);
    rd(ADDR_INPUT);
    chk(32'(q[0]), 32'h1);
    adc(5'd0, 8'd81);
    rd(ADDR_INPUT);
    chk(32'(q[0]), 32'h1);
    adc(5'd0, 8'd80);
    rd(ADDR_INPUT);
    chk(32'(q[0]), 32'h0);
    wr(ADDR_MODE, 32'h1);
    rd(ADDR_ANALOG);
    chk(32'(q[7:0]), 32'h50);
  endtask : t_inputs

  // Mode 2, 4X forward: B rising from rest counts up; code 20 passes only the 2.5 V threshold
  task t_enc;
    wr(ADDR_MODE, 32'h42);
    adc(5'd17, 8'd20);
    rd(ADDR_ENC);
    chk(q, 32'h1);
  endtask : t_enc

  // Second reset with the lower bank dead, then 500 exchanges flip the green lamp
  task t_lowv;
    ok_lo <= 1'b0;
    arst_n <= 1'b0;
    wt(2);
    arst_n <= 1'b1;
    wt(10);
    rd(ADDR_FAULT);
    chk(32'(q[4:0]), 32'h9);
    ok_lo <= 1'b1;
    wt(8);
    wr(ADDR_FAULT, 32'h9);
    rd(ADDR_FAULT);
    chk(32'(q[4:0]), 32'h0);
    repeat (499) rd(ADDR_INPUT);
    chk(32'(alamp), 32'h0);
    rd(ADDR_INPUT);
    chk(32'(alamp), 32'h1);
  endtask : t_lowv

  initial begin
    {arst_n, jmp, av, ach, acode, shrt, otmp} = '0;
    {ok_up, ok_lo, sep} = 3'h7;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    wt(3);
    t_reset;
    t_gate;
    t_short;
    t_wdog;
    t_setup;
    t_inputs;
    t_enc;
    t_lowv;
    print_verdict;
  end
endmodule : fiow_supervisor_tb
